// ==== rtl/uart_pkg.sv ====
// Function
// - Receive polarity bit set makes logic 0 the idle receive level, else 1.
// - High-speed baud bit gives 4 ticks per bit, otherwise 16 ticks.
// - Format field: 11 9N, 10 8 odd, 01 8 even, 00 8N.
// - Stop bit select gives two stop bits when 1, one when 0.
package uart_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 3;
	localparam int DATA_W = 16;
	localparam int CHAR_W = 9;
	localparam int MODE_W = 5;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] MODE_OFS = 3'h0;
	localparam logic [ADDR_W-1:0] DIV_OFS = 3'h1;
	localparam logic [ADDR_W-1:0] TXD_OFS = 3'h2;
	localparam logic [ADDR_W-1:0] RXD_OFS = 3'h3;
	localparam logic [ADDR_W-1:0] STAT_OFS = 3'h4;

	// ----------------------------------------------------------------
	// Mode register fields
	// ----------------------------------------------------------------
	localparam int RXINV_BIT = 4;
	localparam int HSPD_BIT = 3;
	localparam int FMT_LSB = 1;
	localparam int STOP2_BIT = 0;

	// ----------------------------------------------------------------
	// Status register fields
	// ----------------------------------------------------------------
	localparam int STAT_TX_READY = 0;
	localparam int STAT_TX_BUSY = 1;
	localparam int STAT_RX_VALID = 2;
	localparam int STAT_PAR_ERR = 3;
	localparam int STAT_FRM_ERR = 4;
	localparam int STAT_OVR = 5;

	// ----------------------------------------------------------------
	// Reset values and tick counts
	// ----------------------------------------------------------------
	localparam logic [MODE_W-1:0] MODE_RST = 5'h00;
	localparam logic [DATA_W-1:0] DIV_RST = 16'h0000;
	localparam logic [4:0] TICKS_STD = 5'h10;
	localparam logic [4:0] TICKS_HS = 5'h04;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FMT_8N = 2'b00,
		FMT_8E = 2'b01,
		FMT_8O = 2'b10,
		FMT_9N = 2'b11
	} fmt_t;

	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_START = 3'b001,
		PH_DATA = 3'b010,
		PH_PAR = 3'b011,
		PH_STOP = 3'b100
	} phase_t;

	// ----------------------------------------------------------------
	// Format decoding shared by both directions
	// ----------------------------------------------------------------
	function automatic logic [3:0] last_bit_idx(input fmt_t fmt);
		last_bit_idx = (fmt == FMT_9N) ? 4'h8 : 4'h7;
	endfunction

	function automatic logic has_parity(input fmt_t fmt);
		has_parity = (fmt == FMT_8E) || (fmt == FMT_8O);
	endfunction

	function automatic logic parity_bit(input fmt_t fmt, input logic [CHAR_W-1:0] data);
		parity_bit = (^data[7:0]) ^ (fmt == FMT_8O);
	endfunction

endpackage

// ==== rtl/char_stream_if.sv ====
`timescale 1ns/1ns
// Character stream with valid/ready handshake
interface char_stream_if;
	import uart_pkg::*;
	logic valid;
	logic ready;
	logic [CHAR_W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ==== rtl/char_buffer.sv ====
`timescale 1ns/1ns
// Two-entry buffer; refuses input when both entries hold data
module char_buffer (
	input wire logic clk_i,
	input wire logic rst_n_i,
	char_stream_if.snk fill,
	char_stream_if.src drain
);
	import uart_pkg::*;

	typedef struct packed {
		logic [1:0][CHAR_W-1:0] mem;
		logic [1:0] cnt;
		logic wr_ptr;
		logic rd_ptr;
	} buf_t;

	buf_t b_reg;
	buf_t b_next;
	logic push;
	logic pop;

	// Handshake terms
	assign fill.ready = (b_reg.cnt != 2'h2);
	assign drain.valid = (b_reg.cnt != 2'h0);
	assign drain.data = b_reg.mem[b_reg.rd_ptr];
	assign push = fill.valid && fill.ready;
	assign pop = drain.valid && drain.ready;

	// Next state of the buffer
	always_comb begin
		b_next = b_reg;
		if (push) begin
			b_next.mem[b_reg.wr_ptr] = fill.data;
			b_next.wr_ptr = ~b_reg.wr_ptr;
		end
		if (pop) begin
			b_next.rd_ptr = ~b_reg.rd_ptr;
		end
		if (push && !pop) begin
			b_next.cnt = b_reg.cnt + 2'h1;
		end else if (pop && !push) begin
			b_next.cnt = b_reg.cnt - 2'h1;
		end
	end

	// State register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			b_reg <= '0;
		end else begin
			b_reg <= b_next;
		end
	end

endmodule

// ==== rtl/uart_frame.sv ====
`timescale 1ns/1ns
// Asynchronous serial port with programmable frame format
module uart_frame (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [uart_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [uart_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [uart_pkg::DATA_W-1:0] reg_rdata_o,
	input wire logic serial_receive_input_i,
	output logic serial_transmit_o
);
	import uart_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [MODE_W-1:0] mode;
		logic [DATA_W-1:0] div;
		logic [DATA_W-1:0] rdata;
		logic [DATA_W-1:0] baud_cnt;
		logic tick;
		logic rx_s1;
		logic rx_s2;
		phase_t rx_st;
		logic [4:0] rx_tick;
		logic [3:0] rx_bit;
		logic [CHAR_W-1:0] rx_sh;
		logic rx_par;
		logic [CHAR_W-1:0] rx_data;
		logic rx_valid;
		logic par_err;
		logic frm_err;
		logic ovr;
		phase_t tx_st;
		logic [4:0] tx_tick;
		logic [3:0] tx_bit;
		logic [CHAR_W-1:0] tx_sh;
		logic tx_out;
	} state_t;

	state_t st_reg;
	state_t st_next;
	logic [1:0] rst_sync_reg;
	logic rst_n;
	logic [4:0] bit_ticks;
	logic [4:0] half_ticks;
	fmt_t fmt;
	logic [3:0] last_idx;
	logic par_on;
	logic [3:0] last_stop;
	logic rx_lvl;
	logic rx_sample;
	logic tx_edge;
	logic tx_busy;

	char_stream_if tx_fill ();
	char_stream_if tx_drain ();

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	// Two-stage release of the asynchronous reset
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// ----------------------------------------------------------------
	// Frame format decode
	// ----------------------------------------------------------------
	// Shared by receiver and transmitter
	assign bit_ticks = st_reg.mode[HSPD_BIT] ? TICKS_HS : TICKS_STD;
	assign half_ticks = bit_ticks >> 1;
	assign fmt = fmt_t'(st_reg.mode[FMT_LSB +: 2]);
	assign last_idx = last_bit_idx(fmt);
	assign par_on = has_parity(fmt);
	assign last_stop = {3'h0, st_reg.mode[STOP2_BIT]};
	// Receive level normalised so that idle reads as 1
	assign rx_lvl = st_reg.rx_s2 ^ st_reg.mode[RXINV_BIT];
	assign rx_sample = st_reg.tick && (st_reg.rx_tick == bit_ticks - 5'h01);
	assign tx_edge = st_reg.tick && (st_reg.tx_tick == bit_ticks - 5'h01);

	// ----------------------------------------------------------------
	// Transmit buffer
	// ----------------------------------------------------------------
	// Writes to the transmit register fill the buffer; the line drains it
	assign tx_fill.valid = reg_wr_i && (reg_addr_i == TXD_OFS);
	assign tx_fill.data = reg_wdata_i[CHAR_W-1:0];
	assign tx_drain.ready = (st_reg.tx_st == PH_IDLE);
	assign tx_busy = (st_reg.tx_st != PH_IDLE) || tx_drain.valid;

	char_buffer u_tx_buf (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n),
		.fill(tx_fill),
		.drain(tx_drain)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		st_next.rdata = 16'h0000;
		// Receive pin synchroniser
		st_next.rx_s1 = serial_receive_input_i;
		st_next.rx_s2 = st_reg.rx_s1;

		// Register writes
		if (reg_wr_i) begin
			case (reg_addr_i)
				MODE_OFS: st_next.mode = reg_wdata_i[MODE_W-1:0];
				DIV_OFS: st_next.div = reg_wdata_i;
				STAT_OFS: begin
					if (reg_wdata_i[STAT_OVR]) begin
						st_next.ovr = 1'b0;
					end
				end
				default: ;
			endcase
		end

		// Register reads; rx data read frees the holding register
		if (reg_rd_i) begin
			case (reg_addr_i)
				MODE_OFS: st_next.rdata = {11'h000, st_reg.mode};
				DIV_OFS: st_next.rdata = st_reg.div;
				RXD_OFS: begin
					st_next.rdata = {7'h00, st_reg.rx_data};
					st_next.rx_valid = 1'b0;
					st_next.par_err = 1'b0;
					st_next.frm_err = 1'b0;
				end
				STAT_OFS: begin
					st_next.rdata[STAT_TX_READY] = tx_fill.ready;
					st_next.rdata[STAT_TX_BUSY] = tx_busy;
					st_next.rdata[STAT_RX_VALID] = st_reg.rx_valid;
					st_next.rdata[STAT_PAR_ERR] = st_reg.par_err;
					st_next.rdata[STAT_FRM_ERR] = st_reg.frm_err;
					st_next.rdata[STAT_OVR] = st_reg.ovr;
				end
				default: ;
			endcase
		end

		// Oversampling tick divider
		if (st_reg.baud_cnt >= st_reg.div) begin // Lowered divisor restarts at once
			st_next.baud_cnt = 16'h0000;
			st_next.tick = 1'b1;
		end else begin
			st_next.baud_cnt = st_reg.baud_cnt + 16'h0001;
		end

		// Receiver
		if (st_reg.tick && st_reg.rx_st != PH_IDLE) begin
			st_next.rx_tick = st_reg.rx_tick + 5'h01;
		end
		case (st_reg.rx_st)
			PH_IDLE: begin
				if (st_reg.tick && !rx_lvl) begin
					st_next.rx_st = PH_START;
					st_next.rx_tick = 5'h00;
				end
			end
			PH_START: begin
				if (st_reg.tick && st_reg.rx_tick == half_ticks - 5'h01) begin
					st_next.rx_tick = 5'h00;
					st_next.rx_bit = 4'h0;
					st_next.rx_sh = '0;
					st_next.rx_st = rx_lvl ? PH_IDLE : PH_DATA;
				end
			end
			PH_DATA: begin
				if (rx_sample) begin
					st_next.rx_tick = 5'h00;
					st_next.rx_sh[st_reg.rx_bit] = rx_lvl;
					st_next.rx_bit = st_reg.rx_bit + 4'h1;
					if (st_reg.rx_bit == last_idx) begin
						st_next.rx_bit = 4'h0;
						st_next.rx_st = par_on ? PH_PAR : PH_STOP;
					end
				end
			end
			PH_PAR: begin
				if (rx_sample) begin
					st_next.rx_tick = 5'h00;
					st_next.rx_par = rx_lvl;
					st_next.rx_st = PH_STOP;
				end
			end
			PH_STOP: begin
				if (rx_sample) begin
					st_next.rx_tick = 5'h00;
					st_next.rx_bit = st_reg.rx_bit + 4'h1;
					if (!rx_lvl || st_reg.rx_bit == last_stop) begin
						st_next.rx_st = PH_IDLE;
						// A new character beats a clear in the same cycle
						if (st_next.rx_valid) begin
							st_next.ovr = 1'b1;
						end else begin
							st_next.rx_data = st_reg.rx_sh;
							st_next.rx_valid = 1'b1;
							st_next.frm_err = !rx_lvl;
							st_next.par_err = par_on && (st_reg.rx_par != parity_bit(fmt, st_reg.rx_sh));
						end
					end
				end
			end
			default: st_next.rx_st = PH_IDLE;
		endcase

		// Transmitter
		if (st_reg.tick && st_reg.tx_st != PH_IDLE) begin
			st_next.tx_tick = st_reg.tx_tick + 5'h01;
		end
		case (st_reg.tx_st)
			PH_IDLE: begin
				st_next.tx_out = 1'b1;
				if (tx_drain.valid) begin
					st_next.tx_sh = tx_drain.data;
					st_next.tx_tick = 5'h00;
					st_next.tx_out = 1'b0;
					st_next.tx_st = PH_START;
				end
			end
			PH_START: begin
				if (tx_edge) begin
					st_next.tx_tick = 5'h00;
					st_next.tx_bit = 4'h0;
					st_next.tx_out = st_reg.tx_sh[0];
					st_next.tx_st = PH_DATA;
				end
			end
			PH_DATA: begin
				if (tx_edge) begin
					st_next.tx_tick = 5'h00;
					if (st_reg.tx_bit == last_idx) begin
						st_next.tx_bit = 4'h0;
						st_next.tx_out = par_on ? parity_bit(fmt, st_reg.tx_sh) : 1'b1;
						st_next.tx_st = par_on ? PH_PAR : PH_STOP;
					end else begin
						st_next.tx_bit = st_reg.tx_bit + 4'h1;
						st_next.tx_out = st_reg.tx_sh[st_reg.tx_bit + 4'h1];
					end
				end
			end
			PH_PAR: begin
				if (tx_edge) begin
					st_next.tx_tick = 5'h00;
					st_next.tx_out = 1'b1;
					st_next.tx_st = PH_STOP;
				end
			end
			PH_STOP: begin
				if (tx_edge) begin
					st_next.tx_tick = 5'h00;
					st_next.tx_bit = st_reg.tx_bit + 4'h1;
					if (st_reg.tx_bit == last_stop) begin
						st_next.tx_st = PH_IDLE;
					end
				end
			end
			default: st_next.tx_st = PH_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// State register and outputs
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.mode <= MODE_RST;
			st_reg.div <= DIV_RST;
			st_reg.tx_out <= 1'b1;
			// Synchroniser starts at the idle level, so no false start follows reset
			st_reg.rx_s1 <= 1'b1;
			st_reg.rx_s2 <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata_o = st_reg.rdata;
	assign serial_transmit_o = st_reg.tx_out;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n);

	chk_rx_idle_level: assert property (
		(st_reg.rx_st == PH_IDLE && st_reg.tick && st_reg.rx_s2 != st_reg.mode[RXINV_BIT])
		|=> st_reg.rx_st == PH_IDLE)
		else $error("receiver left idle on the idle level");

	chk_tick_per_bit: assert property (
		(st_reg.tx_st != PH_IDLE && $stable(st_reg.mode))
		|-> st_reg.tx_tick < (st_reg.mode[HSPD_BIT] ? 5'h04 : 5'h10))
		else $error("bit period exceeded its tick count");

	chk_data_count: assert property (
		(st_reg.tx_st == PH_DATA && tx_edge && st_reg.tx_bit == last_idx && $stable(st_reg.mode))
		|=> st_reg.tx_st == (par_on ? PH_PAR : PH_STOP))
		else $error("wrong data bit count before parity or stop");

	chk_stop_count: assert property (
		(st_reg.tx_st == PH_PAR && tx_edge && !st_reg.mode[STOP2_BIT] && $stable(st_reg.mode))
		|=> st_reg.tx_st == PH_STOP ##1 (st_reg.tx_st == PH_STOP)[*1] ##0
		(st_reg.tx_out && st_reg.tx_bit == 4'h0))
		else $error("stop phase not entered with line high");

	chk_tx_parity: assert property (
		st_reg.tx_st == PH_PAR |-> st_reg.tx_out == parity_bit(fmt, st_reg.tx_sh))
		else $error("transmitted parity bit wrong");

	cov_rx_char: cover property (st_reg.rx_st == PH_STOP ##1 st_reg.rx_valid);
	cov_tx_parity: cover property (st_reg.tx_st == PH_PAR);
	cov_two_stop: cover property (st_reg.tx_st == PH_STOP && st_reg.tx_bit == 4'h1);
	cov_overrun: cover property ($rose(st_reg.ovr));

endmodule

// ==== tb/serial_peer.sv ====
`timescale 1ns/1ns
// Far-side serial peer: drives the receive line, decodes the transmit line
module serial_peer (
	input wire logic ref_clk_i,
	input wire logic inv_i,
	input wire logic tx_line_i,
	output logic rx_line_o
);
	logic bit_val = 1'b1;

	// Logical level is flipped on the wire while inversion is chosen
	assign rx_line_o = bit_val ^ inv_i;

	// One bit cell of bt clocks
	task automatic put_bit(input logic v, input int bt);
		bit_val <= v;
		repeat (bt) @(posedge ref_clk_i);
	endtask

	// Whole frame: start, data LSB first, optional parity, stop bits
	task automatic send(input logic [15:0] d, input int nd, input int pb, input logic par, input int st,
		input int bt);
		@(posedge ref_clk_i);
		put_bit(1'b0, bt);
		for (int i = 0; i < nd; i++) put_bit(d[i], bt);
		if (pb != 0) put_bit(par, bt);
		for (int i = 0; i < st; i++) put_bit(1'b1, bt);
	endtask

	// Waits for a start edge, samples each cell in its middle
	task automatic get(input int nd, input int pb, input int st, input int bt, output logic [9:0] v,
		output logic ok, output longint t0);
		int k;
		v = '0;
		for (k = 0; k < 9000 && tx_line_i !== 1'b0; k++) @(negedge ref_clk_i);
		ok = (k < 9000);
		t0 = $time / 100;
		repeat (bt / 2) @(negedge ref_clk_i);
		for (k = 0; k < nd + pb; k++) begin
			repeat (bt) @(negedge ref_clk_i);
			v[k] = tx_line_i;
		end
		for (k = 0; k < st; k++) begin
			repeat (bt) @(negedge ref_clk_i);
			ok &= (tx_line_i === 1'b1);
		end
	endtask
endmodule

// ==== tb/uart_frame_format_config_bench.sv ====
`timescale 1ns/1ns
// Self-checking bench for the programmable frame format
module uart_frame_format_config_bench;
	import uart_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic rx_line;
	logic tx_line;
	logic inv = 1'b0;
	logic [31:0] seed = 32'h00006FA8;
	int error_cnt = 0;
	int checked = 0;
	logic [4:0] modes [5] = '{5'h00, 5'h03, 5'h0C, 5'h1F, 5'h12};

	// Clock of 100 ns
	always #50 ref_clk_i = ~ref_clk_i;

	uart_frame DUT (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.reg_addr_i(addr),
		.reg_wdata_i(wdata),
		.reg_wr_i(wr),
		.reg_rd_i(rd),
		.reg_rdata_o(rdata),
		.serial_receive_input_i(rx_line),
		.serial_transmit_o(tx_line)
	);

	serial_peer peer (
		.ref_clk_i(ref_clk_i),
		.inv_i(inv),
		.tx_line_i(tx_line),
		.rx_line_o(rx_line)
	);

	// ----------------------------------------------------------------
	// Model and helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] xorshift();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction

	// Frame shape from the mode bits
	function automatic void dec(input logic [4:0] md, output int nd, output int pb, output int st, output int bt);
		nd = (md[2:1] == 2'b11) ? 9 : 8;
		pb = md[2] ^ md[1];
		st = md[0] ? 2 : 1;
		bt = md[3] ? 4 : 16;
	endfunction

	task automatic test_done();
		$display("Comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t %s got %h want %h", $time, msg, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge ref_clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk_i);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge ref_clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk_i);
		rd <= 1'b0;
		@(negedge ref_clk_i);
		d = rdata;
	endtask

	// Receives one transmitted word and compares it with the model
	task automatic tx_word(input logic [15:0] w, input logic [4:0] md, output longint t);
		logic [9:0] v;
		logic ok;
		int nd, pb, st, bt;
		dec(md, nd, pb, st, bt);
		peer.get(nd, pb, st, bt, v, ok, t);
		if (pb != 0) w[8] = (^w[7:0]) ^ md[2];
		check(v, w, "tx char");
		check(ok, 1'b1, "tx stop level");
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int nd, pb, st, bt, k, n;
		logic [15:0] d, r;
		logic par;
		longint t0, t1;
		logic [15:0] q [$];
		repeat (3) @(negedge ref_clk_i);
		check(rdata, 16'h0000, "rdata in reset");
		check(tx_line, 1'b1, "tx idle in reset");
		@(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		rd_reg(MODE_OFS, r);
		check(r, 16'h0000, "mode reset");
		rd_reg(3'h7, r);
		check(r, 16'h0000, "unmapped read");
		// Divisor holds what was written; put back to one tick per clock
		d = xorshift();
		wr_reg(DIV_OFS, d);
		rd_reg(DIV_OFS, r);
		check(r, d, "divisor readback");
		wr_reg(DIV_OFS, 16'h0000);
		foreach (modes[m]) begin
			dec(modes[m], nd, pb, st, bt);
			// Let the last stop bit finish before the format changes
			repeat (40) @(posedge ref_clk_i);
			wr_reg(MODE_OFS, {11'h000, modes[m]});
			inv <= modes[m][4];
			// Flush anything the polarity change may have started
			repeat (640) @(posedge ref_clk_i);
			rd_reg(RXD_OFS, r);
			wr_reg(STAT_OFS, 16'h0020);
			rd_reg(MODE_OFS, r);
			check(r, {11'h000, modes[m]}, "mode readback");
			// Receive: a good char, then one with flipped parity when the format has a parity bit
			for (k = 0; k < 2; k++) begin
				d = xorshift() & ((1 << nd) - 1);
				par = (^d[7:0]) ^ modes[m][2] ^ logic'(k & pb);
				peer.send(d, nd, pb, par, st, bt);
				for (n = 0; n < 50; n++) begin
					rd_reg(STAT_OFS, r);
					if (r[STAT_RX_VALID] === 1'b1) break;
				end
				check(r[5:2], {2'b00, logic'(k & pb), 1'b1}, "rx status");
				if (n == 50) test_done();
				rd_reg(RXD_OFS, r);
				check(r, d, "rx char");
			end
			// Transmit two words back to back
			d = xorshift() & ((1 << nd) - 1);
			r = xorshift() & ((1 << nd) - 1);
			fork
				begin
					wr_reg(TXD_OFS, d);
					wr_reg(TXD_OFS, r);
				end
				begin
					tx_word(d, modes[m], t0);
					tx_word(r, modes[m], t1);
				end
			join
			n = (1 + nd + pb + st) * bt;
			check((t1 - t0) >= n && (t1 - t0) <= n + 1, 1'b1, "frame spacing");
		end
		// Fill the transmit buffer until it refuses, then drain it
		fork
			begin
				rd_reg(STAT_OFS, r);
				for (n = 0; n < 8 && r[STAT_TX_READY] === 1'b1; n++) begin
					q.push_back(xorshift() & 16'h00FF);
					wr_reg(TXD_OFS, q[$]);
					rd_reg(STAT_OFS, r);
				end
			end
			begin
				// Watch the line only once the first word is queued
				for (k = 0; k < 50 && q.size() == 0; k++) @(negedge ref_clk_i);
				for (k = 0; k < 8 && k < q.size(); k++) tx_word(q[k], 5'h12, t0);
			end
		join
		check(n >= 2 && n < 8, 1'b1, "buffer depth");
		check(k, n, "buffer drained");
		test_done();
	end
endmodule
